/* File: irq_hdr_pkg.sv */
// constants shared by the disk controller interrupt and header fault logic
package irq_hdr_pkg;

    // ==================== register offsets
    localparam logic [3:0] status_off = 4'h0;
    localparam logic [3:0] error_off = 4'h1;
    localparam logic [3:0] op_setup_off = 4'h2;
    localparam logic [3:0] drive_cmd_off = 4'h3;
    localparam logic [3:0] lock_release_off = 4'h4;
    localparam logic [3:0] control_off = 4'h5;
    localparam logic [3:0] match_en_off = 4'h6;
    localparam logic [3:0] pattern_base_off = 4'h8;

    // ==================== status register fields
    localparam int st_next_cmd = 0;
    localparam int st_hdr_done = 1;
    localparam int st_err_seen = 2;
    localparam int st_corr_done = 3;
    localparam int st_lock_wait = 4;
    localparam int st_busy = 5;

    // ==================== error register fields
    localparam int er_crc = 0;
    localparam int er_overrun = 1;
    localparam int er_sync = 2;
    localparam int er_fifo_lost = 3;
    localparam int er_corr_failed = 4;
    localparam int er_late_lock = 5;
    localparam int er_partial = 6;

    // ==================== setup, command and control fields
    localparam int os_host_alert = 0;
    localparam int os_hdr_alert = 1;
    localparam int os_lockstep = 2;
    localparam int dc_hdr_lsb = 0;
    localparam int dc_data_lsb = 2;
    localparam int dc_drive_en = 4;
    localparam int ctl_chip_clear = 0;

    // ==================== reset values
    localparam logic [7:0] op_setup_rst = 8'h00;
    localparam logic [7:0] drive_cmd_rst = 8'h00;
    localparam logic [5:0] match_en_rst = 6'h00;

    // ==================== header geometry
    localparam int hdr_bytes = 6;

    // ==================== operation codes
    typedef enum logic [1:0] {
        hdr_ignore = 2'h0,
        hdr_read = 2'h1,
        hdr_compare = 2'h2,
        hdr_write = 2'h3
    } hdr_op_t;

    typedef enum logic [1:0] {
        data_read = 2'h0,
        data_check = 2'h1,
        data_write = 2'h2,
        data_none = 2'h3
    } data_op_t;

    // ==================== sector phase
    typedef enum logic [2:0] {
        ph_idle = 3'b001,
        ph_header = 3'b010,
        ph_data = 3'b100
    } phase_t;

endpackage

/* File: hdr_pattern_mem.sv */
// small memory of expected header bytes with a registered read port
`timescale 1ns/1ps
module hdr_pattern_mem (
    // clock
    input wire logic mclk_i,
    // write port
    input wire logic wr_i,
    input wire logic [2:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // read port
    input wire logic [2:0] raddr_i,
    output logic [7:0] rdata_o
);

    // ==================== storage
    // no reset: contents are defined by software before any compare
    logic [7:0] mem_q [0:7];

    always_ff @(posedge mclk_i) begin
        if (wr_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end

endmodule // hdr_pattern_mem

/* File: disk_irq_ctrl.sv */
// interrupt, flag and header fault logic of the disk data controller
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module disk_irq_ctrl (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // sequencer events
    input wire logic cmd_start_i,
    input wire logic multi_sector_i,
    input wire logic hdr_done_i,
    input wire logic data_end_i,
    input wire logic op_done_i,
    // disk header byte stream
    input wire logic hdr_byte_valid_i,
    input wire logic [2:0] hdr_byte_idx_i,
    input wire logic [7:0] hdr_byte_i,
    // error sources
    input wire logic crc_err_i,
    input wire logic overrun_i,
    input wire logic sync_err_i,
    input wire logic fifo_lost_i,
    input wire logic corr_done_i,
    input wire logic corr_fail_i,
    // sequencer controls
    output logic [7:0] active_cmd_o,
    output logic terminate_o,
    output logic xfer_block_o,
    output logic hdr_fifo_wr_o,
    output logic [7:0] hdr_fifo_data_o,
    // interrupt pin
    output logic alert_n_o
);

    // ==================== register strobes
    logic wr_setup, wr_cmd, wr_lock, wr_ctl, wr_match, wr_pat, rd_status;
    logic chip_clear;

    assign wr_setup = wr_i && (addr_i == irq_hdr_pkg::op_setup_off);
    assign wr_cmd = wr_i && (addr_i == irq_hdr_pkg::drive_cmd_off);
    assign wr_lock = wr_i && (addr_i == irq_hdr_pkg::lock_release_off);
    assign wr_ctl = wr_i && (addr_i == irq_hdr_pkg::control_off);
    assign wr_match = wr_i && (addr_i == irq_hdr_pkg::match_en_off);
    assign wr_pat = wr_i && (addr_i[3] == 1'b1) && (addr_i[2:0] < 3'h6);
    assign rd_status = rd_i && (addr_i == irq_hdr_pkg::status_off);
    assign chip_clear = wr_ctl && wdata_i[irq_hdr_pkg::ctl_chip_clear];

    // ==================== setup and command registers
    logic [7:0] op_setup_q;
    logic [7:0] drive_cmd_q;
    logic [7:0] active_cmd_q;
    logic [5:0] match_en_q;
    logic host_alert_en, hdr_alert_en, lockstep_en;

    assign host_alert_en = op_setup_q[irq_hdr_pkg::os_host_alert];
    assign hdr_alert_en = op_setup_q[irq_hdr_pkg::os_hdr_alert];
    assign lockstep_en = op_setup_q[irq_hdr_pkg::os_lockstep];

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_setup_q <= irq_hdr_pkg::op_setup_rst;
            drive_cmd_q <= irq_hdr_pkg::drive_cmd_rst;
            match_en_q <= irq_hdr_pkg::match_en_rst;
        end else if (chip_clear) begin
            op_setup_q <= irq_hdr_pkg::op_setup_rst;
            drive_cmd_q <= irq_hdr_pkg::drive_cmd_rst;
            match_en_q <= irq_hdr_pkg::match_en_rst;
        end else begin
            if (wr_setup) begin
                op_setup_q <= wdata_i;
            end
            if (wr_cmd) begin
                drive_cmd_q <= wdata_i;
            end
            if (wr_match) begin
                match_en_q <= wdata_i[5:0];
            end
        end
    end

    // ==================== sector phase
    irq_hdr_pkg::phase_t phase_q;
    logic hdr_begin;

    // the working copy is loaded only at a header start, so the host may
    // rewrite the command while the current data field is still running
    assign hdr_begin = cmd_start_i
        || (data_end_i && multi_sector_i && (phase_q == irq_hdr_pkg::ph_data));

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= irq_hdr_pkg::ph_idle;
            active_cmd_q <= irq_hdr_pkg::drive_cmd_rst;
        end else if (chip_clear || terminate_o || op_done_i) begin
            phase_q <= irq_hdr_pkg::ph_idle;
        end else begin
            if (hdr_begin) begin
                active_cmd_q <= drive_cmd_q;
            end
            case (phase_q)
                irq_hdr_pkg::ph_idle: begin
                    if (cmd_start_i) begin
                        phase_q <= irq_hdr_pkg::ph_header;
                    end
                end
                irq_hdr_pkg::ph_header: begin
                    if (hdr_done_i) begin
                        phase_q <= irq_hdr_pkg::ph_data;
                    end
                end
                irq_hdr_pkg::ph_data: begin
                    if (hdr_begin) begin
                        phase_q <= irq_hdr_pkg::ph_header;
                    end else if (data_end_i) begin
                        phase_q <= irq_hdr_pkg::ph_idle;
                    end
                end
                default: begin
                    phase_q <= irq_hdr_pkg::ph_idle;
                end
            endcase
        end
    end

    assign active_cmd_o = active_cmd_q;

    // ==================== header compare
    logic [7:0] pat_byte;
    logic cmp_valid_q;
    logic [2:0] cmp_idx_q;
    logic [7:0] cmp_byte_q;
    logic is_compare, is_read_hdr, is_check;
    logic en_match_q, mismatch_q, en_match_d, mismatch_d;
    logic byte_eq;

    hdr_pattern_mem u_pattern (
        .mclk_i(mclk_i),
        .wr_i(wr_pat),
        .waddr_i(addr_i[2:0]),
        .wdata_i(wdata_i),
        .raddr_i(hdr_byte_idx_i),
        .rdata_o(pat_byte)
    );

    assign is_compare = active_cmd_q[irq_hdr_pkg::dc_hdr_lsb +: 2] == irq_hdr_pkg::hdr_compare;
    assign is_read_hdr = active_cmd_q[irq_hdr_pkg::dc_hdr_lsb +: 2] == irq_hdr_pkg::hdr_read;
    assign is_check = active_cmd_q[irq_hdr_pkg::dc_data_lsb +: 2] == irq_hdr_pkg::data_check;
    assign byte_eq = cmp_byte_q == pat_byte;

    // the pattern arrives one cycle after the disk byte, so the byte is delayed to meet it
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_valid_q <= 1'b0;
            cmp_idx_q <= 3'h0;
            cmp_byte_q <= 8'h00;
        end else begin
            cmp_valid_q <= hdr_byte_valid_i;
            cmp_idx_q <= hdr_byte_idx_i;
            cmp_byte_q <= hdr_byte_i;
        end
    end

    always_comb begin
        en_match_d = en_match_q;
        mismatch_d = mismatch_q;
        if (cmp_valid_q && is_compare) begin
            if (byte_eq && match_en_q[cmp_idx_q]) begin
                en_match_d = 1'b1;
            end
            if (!byte_eq) begin
                mismatch_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_match_q <= 1'b0;
            mismatch_q <= 1'b0;
        end else if (hdr_begin || chip_clear) begin
            en_match_q <= 1'b0;
            mismatch_q <= 1'b0;
        end else begin
            en_match_q <= en_match_d;
            mismatch_q <= mismatch_d;
        end
    end

    // header bytes go to the fifo on read header and on compare with check data
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hdr_fifo_wr_o <= 1'b0;
            hdr_fifo_data_o <= 8'h00;
        end else begin
            hdr_fifo_wr_o <= cmp_valid_q && (is_read_hdr || (is_compare && is_check));
            hdr_fifo_data_o <= cmp_byte_q;
        end
    end

    // ==================== lockstep
    logic lock_wait_q;
    logic late_lock;

    assign late_lock = lock_wait_q && data_end_i && !wr_lock;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_wait_q <= 1'b0;
        end else if (chip_clear || terminate_o || op_done_i) begin
            lock_wait_q <= 1'b0;
        end else if (hdr_done_i && lockstep_en) begin
            lock_wait_q <= 1'b1;
        end else if (wr_lock) begin
            lock_wait_q <= 1'b0;
        end
    end

    // ==================== error register
    logic [6:0] err_q;
    logic [6:0] err_set;
    logic partial_hit;

    // write, read and ignore header never reach this term
    assign partial_hit = hdr_done_i && is_compare && en_match_d && mismatch_d;

    always_comb begin
        err_set = 7'h00;
        err_set[irq_hdr_pkg::er_crc] = crc_err_i;
        err_set[irq_hdr_pkg::er_overrun] = overrun_i;
        err_set[irq_hdr_pkg::er_sync] = sync_err_i;
        err_set[irq_hdr_pkg::er_fifo_lost] = fifo_lost_i;
        err_set[irq_hdr_pkg::er_corr_failed] = corr_done_i && corr_fail_i;
        err_set[irq_hdr_pkg::er_late_lock] = late_lock;
        err_set[irq_hdr_pkg::er_partial] = partial_hit;
    end

    // error bits hold until the next command or a clear, so both
    // crc and partial errors remain visible after termination
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_q <= 7'h00;
        end else if (chip_clear) begin
            err_q <= 7'h00;
        end else if (cmd_start_i) begin
            err_q <= err_set;
        end else begin
            err_q <= err_q | err_set;
        end
    end

    // ==================== termination and data block
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            terminate_o <= 1'b0;
            xfer_block_o <= 1'b0;
        end else begin
            terminate_o <= !chip_clear && (partial_hit || late_lock);
            if (chip_clear || cmd_start_i) begin
                xfer_block_o <= 1'b0;
            end else if (partial_hit && is_check) begin
                xfer_block_o <= 1'b1;
            end
        end
    end

    // ==================== status flags
    logic [3:0] st_q;
    logic [3:0] st_set;
    logic err_event;

    // a correction failure alone raises no extra event; the end of cycle covers it
    assign err_event = |(err_set & ~(7'h01 << irq_hdr_pkg::er_corr_failed));

    always_comb begin
        st_set = 4'h0;
        st_set[irq_hdr_pkg::st_next_cmd] = op_done_i || terminate_o;
        st_set[irq_hdr_pkg::st_hdr_done] = hdr_done_i;
        st_set[irq_hdr_pkg::st_err_seen] = err_event;
        st_set[irq_hdr_pkg::st_corr_done] = corr_done_i;
    end

    // a set in the same cycle as the status read wins over the clear
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= 4'h0;
        end else if (chip_clear) begin
            st_q <= 4'h0;
        end else if (rd_status) begin
            st_q <= st_set;
        end else begin
            st_q <= st_q | st_set;
        end
    end

    // ==================== alert pin
    logic pending_q, held_q, pending_d;
    logic alert_event;

    always_comb begin
        alert_event = op_done_i || terminate_o || err_event || corr_done_i;
        if (hdr_done_i && hdr_alert_en) begin
            alert_event = 1'b1;
        end
        if (rd_status) begin
            pending_d = 1'b0;
        end else begin
            pending_d = pending_q || held_q || alert_event;
        end
    end

    // drive_enable_bit plays no part here, so dropping it keeps the alert
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_q <= 1'b0;
            held_q <= 1'b0;
            alert_n_o <= 1'b1;
        end else if (chip_clear) begin
            pending_q <= 1'b0;
            held_q <= 1'b0;
            alert_n_o <= 1'b1;
        end else begin
            pending_q <= pending_d;
            held_q <= rd_status && alert_event;
            alert_n_o <= !(host_alert_en && pending_d);
        end
    end

    // ==================== read port
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (addr_i)
            irq_hdr_pkg::status_off: begin
                rd_mux[3:0] = st_q;
                rd_mux[irq_hdr_pkg::st_lock_wait] = lock_wait_q;
                rd_mux[irq_hdr_pkg::st_busy] = phase_q != irq_hdr_pkg::ph_idle;
            end
            irq_hdr_pkg::error_off: begin
                rd_mux[6:0] = err_q;
            end
            irq_hdr_pkg::op_setup_off: begin
                rd_mux = op_setup_q;
            end
            irq_hdr_pkg::drive_cmd_off: begin
                rd_mux = drive_cmd_q;
            end
            irq_hdr_pkg::match_en_off: begin
                rd_mux[5:0] = match_en_q;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule // disk_irq_ctrl

/* File: disk_irq_ctrl_asserts.sv */
// port-level assertion checker for the disk interrupt controller
`timescale 1ns/1ps
module disk_irq_ctrl_asserts (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    // events
    input wire logic hdr_done_i,
    input wire logic op_done_i,
    input wire logic crc_err_i,
    input wire logic overrun_i,
    input wire logic sync_err_i,
    input wire logic fifo_lost_i,
    input wire logic corr_done_i,
    // outputs
    input wire logic terminate_o,
    input wire logic hdr_fifo_wr_o,
    input wire logic alert_n_o
);
    // ====================
    // shadow of the setup enables, chip clear wipes it like a reset
    logic [2:0] en_q;
    wire logic st_rd = rd_i && addr_i == irq_hdr_pkg::status_off;
    wire logic clr = wr_i && addr_i == irq_hdr_pkg::control_off && wdata_i[0];
    wire logic quiet = en_q[0] && !st_rd && !wr_i;
    wire logic err_ev = crc_err_i || overrun_i || sync_err_i || fifo_lost_i;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_q <= 3'h0;
        end else if (clr) begin
            en_q <= 3'h0;
        end else if (wr_i && addr_i == irq_hdr_pkg::op_setup_off) begin
            en_q <= wdata_i[2:0];
        end
    end
    // ====================
    // properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rd_rel; st_rd |=> alert_n_o; endproperty
    a_rd_rel: assert property (p_rd_rel) else $error("alert kept after status read");
    property p_rd_late; st_rd && op_done_i && en_q[0] |=> alert_n_o ##1 !alert_n_o; endproperty
    a_rd_late: assert property (p_rd_late) else $error("event in read lost");
    property p_clr; clr |=> alert_n_o [*2]; endproperty
    a_clr: assert property (p_clr) else $error("chip clear kept alert");
    property p_off; !en_q[0] [*2] |-> alert_n_o; endproperty
    a_off: assert property (p_off) else $error("alert while disabled");
    property p_done; op_done_i && quiet |=> !alert_n_o; endproperty
    a_done: assert property (p_done) else $error("no alert on completion");
    property p_hdr; hdr_done_i && quiet && en_q[1] |=> !alert_n_o; endproperty
    a_hdr: assert property (p_hdr) else $error("no header alert");
    property p_corr; corr_done_i && quiet |=> !alert_n_o; endproperty
    a_corr: assert property (p_corr) else $error("no correction alert");
    property p_err; err_ev && quiet |=> !alert_n_o; endproperty
    a_err: assert property (p_err) else $error("no error alert");
    property p_hold; !alert_n_o && !st_rd && !wr_i |=> !alert_n_o; endproperty
    a_hold: assert property (p_hold) else $error("alert dropped while pending");
    property p_drv; !alert_n_o && wr_i && addr_i == irq_hdr_pkg::drive_cmd_off |=> !alert_n_o;
    endproperty
    a_drv: assert property (p_drv) else $error("command write dropped alert");
    property p_term; terminate_o |=> !terminate_o; endproperty
    a_term: assert property (p_term) else $error("terminate longer than one cycle");
    c_alert: cover property (!alert_n_o);
    c_term: cover property (terminate_o);
    c_fifo: cover property (hdr_fifo_wr_o);
endmodule // disk_irq_ctrl_asserts

bind disk_irq_ctrl disk_irq_ctrl_asserts i_disk_irq_ctrl_asserts (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .hdr_done_i(hdr_done_i), .op_done_i(op_done_i), .crc_err_i(crc_err_i),
    .overrun_i(overrun_i), .sync_err_i(sync_err_i), .fifo_lost_i(fifo_lost_i),
    .corr_done_i(corr_done_i), .terminate_o(terminate_o), .hdr_fifo_wr_o(hdr_fifo_wr_o),
    .alert_n_o(alert_n_o));

/* File: host_model.sv */
// host processor model driving the controller register port
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic mclk_i,
    // register port
    output logic [3:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i
);
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // released lines show the inverse so stale values never look valid
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
    task automatic service(output logic [7:0] st, output logic [7:0] er);
        bus_rd(irq_hdr_pkg::status_off, st);
        er = 8'h00;
        if (st[irq_hdr_pkg::st_err_seen]) begin
            bus_rd(irq_hdr_pkg::error_off, er);
        end
    endtask
    task automatic reload_release(input logic [7:0] cmd);
        bus_wr(irq_hdr_pkg::drive_cmd_off, cmd);
        bus_wr(irq_hdr_pkg::lock_release_off, 8'h00);
    endtask
endmodule // host_model

/* File: disk_irq_ctrl_bench.sv */
// self-checking bench for the disk interrupt controller
`timescale 1ns/1ps
module disk_irq_ctrl_bench;
    logic mclk_i;
    logic rst_n_i;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, active_cmd, fifo_data, st, er, cmd;
    logic [7:0] pat [6];
    logic wr, rd, term, xblk, fifo_wr, alert_n, multi, corr_fail, bvalid, exp;
    logic [2:0] bidx;
    logic [7:0] bbyte;
    logic [8:0] ev;
    logic [5:0] men, mis;
    int n_fail, samples_checked, seed, cyc, n_term, n_fifo, t0, f0;
    // ====================
    // design, host and clock
    disk_irq_ctrl i_disk_irq_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmd_start_i(ev[0]),
        .multi_sector_i(multi), .hdr_done_i(ev[1]), .data_end_i(ev[2]), .op_done_i(ev[3]),
        .hdr_byte_valid_i(bvalid), .hdr_byte_idx_i(bidx), .hdr_byte_i(bbyte),
        .crc_err_i(ev[4]), .overrun_i(ev[5]), .sync_err_i(ev[6]), .fifo_lost_i(ev[7]),
        .corr_done_i(ev[8]), .corr_fail_i(corr_fail), .active_cmd_o(active_cmd),
        .terminate_o(term), .xfer_block_o(xblk), .hdr_fifo_wr_o(fifo_wr),
        .hdr_fifo_data_o(fifo_data), .alert_n_o(alert_n));
    host_model i_host_model (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata));
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        n_term += (term === 1'b1);
        n_fifo += (fifo_wr === 1'b1);
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    // ====================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    task automatic pulse(input logic [8:0] m);
        @(posedge mclk_i);
        ev <= m;
        @(posedge mclk_i);
        ev <= 9'h0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic feed(input logic [5:0] m);
        for (int k = 0; k < 6; k++) begin
            @(posedge mclk_i);
            bvalid <= 1'b1;
            bidx <= 3'(k);
            bbyte <= m[k] ? ~pat[k] : pat[k];
        end
        @(posedge mclk_i);
        bvalid <= 1'b0;
        bbyte <= ~bbyte;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ====================
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        ev = 9'h0;
        {multi, corr_fail, bvalid, bidx, bbyte} = '0;
        {n_fail, samples_checked, cyc, n_term, n_fifo} = '0;
        seed = 57197;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        tick(1);
        check({alert_n, term, xblk, fifo_wr, active_cmd[3:0]}, 8'h80, "reset outputs");
        i_host_model.bus_rd(irq_hdr_pkg::op_setup_off, st);
        check(st, irq_hdr_pkg::op_setup_rst, "setup reset");
        i_host_model.bus_rd(4'h7, st);
        check(st, 8'h00, "unmapped read");
        pulse(9'h008);
        tick(2);
        check({7'h0, alert_n}, 8'h01, "alert while disabled");
        i_host_model.service(st, er);
        check(st & 8'h0f, 8'h01, "completion flag");
        $display("test disabled alert done");
        i_host_model.bus_wr(irq_hdr_pkg::op_setup_off, 8'h01);
        for (int i = 0; i < 4; i++) begin
            pulse(9'h001);
            tick($unsigned($random(seed)) % 4);
            pulse(9'h010 << i);
            tick(1);
            check({7'h0, alert_n}, 8'h00, "error alert");
            i_host_model.service(st, er);
            check(st & 8'h0f, 8'h04, "error seen flag");
            check(er, 8'h01 << i, "error bit");
            check({7'h0, alert_n}, 8'h01, "alert after status read");
        end
        $display("test error sources done");
        for (int i = 0; i < 2; i++) begin
            corr_fail <= i[0];
            pulse(9'h108);
            tick(1);
            check({7'h0, alert_n}, 8'h00, "correction alert");
            i_host_model.bus_rd(irq_hdr_pkg::status_off, st);
            check(st & 8'h0f, 8'h09, "correction flag");
            i_host_model.bus_rd(irq_hdr_pkg::error_off, er);
            check({7'h0, er[4]}, 8'(i), "correction failed bit");
        end
        $display("test correction done");
        fork
            i_host_model.bus_rd(irq_hdr_pkg::status_off, st);
            pulse(9'h008);
        join
        check({7'h0, alert_n}, 8'h01, "alert during read");
        tick(1);
        check({7'h0, alert_n}, 8'h00, "alert after read");
        i_host_model.bus_wr(irq_hdr_pkg::drive_cmd_off, 8'h00);
        tick(1);
        check({7'h0, alert_n}, 8'h00, "drive enable cleared");
        i_host_model.bus_wr(irq_hdr_pkg::control_off, 8'h01);
        #1;
        check({7'h0, alert_n}, 8'h01, "chip clear");
        $display("test alert clearing done");
        i_host_model.bus_wr(irq_hdr_pkg::op_setup_off, 8'h01);
        for (int t = 0; t < 8; t++) begin
            for (int k = 0; k < 6; k++) begin
                pat[k] = 8'($random(seed));
                i_host_model.bus_wr(irq_hdr_pkg::pattern_base_off + 4'(k), pat[k]);
            end
            men = 6'($random(seed));
            mis = 6'($random(seed));
            if (t == 2) mis = 6'h00;
            if (t == 6) begin
                men = 6'h21;
                mis = 6'h20;
            end
            cmd = {3'h0, 1'b1, 2'h1, 2'(t)};
            exp = (t % 4 == 2) && |(men & ~mis) && |mis;
            i_host_model.bus_wr(irq_hdr_pkg::match_en_off, {2'h0, men});
            i_host_model.bus_wr(irq_hdr_pkg::drive_cmd_off, cmd);
            pulse(9'h001);
            tick(1);
            check(active_cmd, cmd, "working command");
            {t0, f0} = {n_term, n_fifo};
            feed(mis);
            #1 check(fifo_data, mis[4] ? ~pat[4] : pat[4], "fifo byte");
            pulse((t % 4 == 2) ? 9'h012 : 9'h002);
            tick(3);
            check(8'(n_term - t0), {7'h0, exp}, "terminate count");
            check({7'h0, xblk}, {7'h0, exp}, "data blocked");
            if (t % 4 == 2) check(8'(n_fifo - f0), 8'h06, "header into fifo");
            i_host_model.bus_rd(irq_hdr_pkg::error_off, er);
            check({7'h0, er[6]}, {7'h0, exp}, "partial header error");
            if (t % 4 == 2) check({7'h0, er[0]}, 8'h01, "crc beside partial");
        end
        $display("test header compare done");
        i_host_model.bus_wr(irq_hdr_pkg::op_setup_off, 8'h07);
        i_host_model.bus_wr(irq_hdr_pkg::match_en_off, 8'h00);
        i_host_model.bus_wr(irq_hdr_pkg::drive_cmd_off, 8'h16);
        multi <= 1'b1;
        pulse(9'h001);
        feed(6'h00);
        pulse(9'h002);
        tick(1);
        check({7'h0, alert_n}, 8'h00, "header alert");
        i_host_model.service(st, er);
        check(st & 8'h12, 8'h12, "header and lock wait flags");
        i_host_model.reload_release(8'h10);
        pulse(9'h004);
        tick(1);
        check(active_cmd, 8'h10, "reloaded command");
        t0 = n_term;
        pulse(9'h002);
        pulse(9'h004);
        tick(2);
        check(8'(n_term - t0), 8'h01, "late lock terminate");
        i_host_model.bus_rd(irq_hdr_pkg::error_off, er);
        check({7'h0, er[5]}, 8'h01, "late lock bit");
        multi <= 1'b0;
        $display("test lockstep done");
        summarize();
    end
endmodule // disk_irq_ctrl_bench
